// ---- common/ocsc_pkg.sv ----
package ocsc_pkg;

  // ---------------------------------------------------------------
  // Clock and frame timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int FRAME_HZ = 105;
  localparam int FRAME_CYCLES = CLK_HZ / FRAME_HZ;
  localparam int FRAME_W = 24;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_ALL_OFF = 8'ha4;
  localparam logic [7:0] OP_ALL_ON = 8'ha5;
  localparam logic [7:0] OP_NORMAL = 8'ha6;
  localparam logic [7:0] OP_INVERSE = 8'ha7;
  localparam logic [7:0] OP_DISP_OFF = 8'hae;
  localparam logic [7:0] OP_DISP_ON = 8'haf;
  localparam logic [7:0] OP_NOP = 8'he3;
  localparam logic [7:0] OP_LOCK = 8'hfd;
  localparam logic [7:0] OP_HSCR_R = 8'h26;
  localparam logic [7:0] OP_HSCR_L = 8'h27;
  localparam logic [7:0] OP_VHSCR_R = 8'h29;
  localparam logic [7:0] OP_VHSCR_L = 8'h2a;
  localparam logic [7:0] OP_VAREA = 8'ha3;
  localparam logic [7:0] OP_CSCR_R = 8'h2c;
  localparam logic [7:0] OP_CSCR_L = 8'h2d;
  localparam logic [7:0] OP_SCR_OFF = 8'h2e;
  localparam logic [7:0] OP_SCR_ON = 8'h2f;

  // ---------------------------------------------------------------
  // Parameter counts and field positions
  // ---------------------------------------------------------------
  localparam logic [2:0] NP_ONE = 3'h1;
  localparam logic [2:0] NP_TWO = 3'h2;
  localparam logic [2:0] NP_VH = 3'h5;
  localparam logic [2:0] NP_SEVEN = 3'h7;
  localparam int LOCK_BIT = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTRAST = 8'h7f;
  localparam logic [7:0] RST_COL_START = 8'h00;
  localparam logic [7:0] RST_COL_END = 8'h7f;
  localparam logic [2:0] RST_PAGE_START = 3'h0;
  localparam logic [2:0] RST_PAGE_END = 3'h7;
  localparam logic [5:0] RST_FIXED_ROWS = 6'h00;
  localparam logic [6:0] RST_SCROLL_ROWS = 7'h40;

  // ---------------------------------------------------------------
  // Register port map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_FRAME = 4'h4;
  localparam logic [3:0] REG_CONTRAST = 4'h8;
  localparam logic [3:0] REG_SCROLL_POS = 4'hc;

  // ---------------------------------------------------------------
  // Decoder states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OPCODE = 2'b01,
    ST_PARAM = 2'b10
  } ocsc_state_t;

  // Bytes expected after an opcode, including the opcodes of command
  // groups that this block does not act on, so that their parameters
  // are skipped and never mistaken for opcodes.
  function automatic logic [2:0] ocsc_nparams(input logic [7:0] op);
    logic [2:0] n;
    n = 3'h0;
    case (op)
      OP_CONTRAST, OP_LOCK: n = NP_ONE;
      OP_HSCR_R, OP_HSCR_L, OP_CSCR_R, OP_CSCR_L: n = NP_SEVEN;
      OP_VHSCR_R, OP_VHSCR_L: n = NP_VH;
      OP_VAREA: n = NP_TWO;
      8'h21, 8'h22: n = NP_TWO;
      8'h20, 8'ha8, 8'had, 8'hd3, 8'hd5: n = NP_ONE;
      8'hd9, 8'hda, 8'hdb, 8'hdc: n = NP_ONE;
      default: n = 3'h0;
    endcase
    return n;
  endfunction : ocsc_nparams

endpackage : ocsc_pkg

// ---- common/ocsc_step_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface ocsc_step_if;
  logic frame_tick;
  logic run;
  logic [2:0] interval;
  logic step;

  modport timer (
    input frame_tick,
    input run,
    input interval,
    output step
  );

  modport ctl (
    output frame_tick,
    output run,
    output interval,
    input step
  );
endinterface : ocsc_step_if

`default_nettype wire

// ---- design/ocsc_step_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module ocsc_step_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Frame and step handshake
  ocsc_step_if.timer sif
);

  logic [8:0] frame_cnt_q;
  logic [8:0] frames;
  logic step_q;

  // ---------------------------------------------------------------
  // Interval code to frames per step
  // ---------------------------------------------------------------
  always_comb
  begin
    case (sif.interval)
      3'h0: frames = 9'h005;
      3'h1: frames = 9'h040;
      3'h2: frames = 9'h080;
      3'h3: frames = 9'h100;
      3'h4: frames = 9'h002;
      3'h5: frames = 9'h003;
      3'h6: frames = 9'h004;
      default: frames = 9'h001;
    endcase
  end

  // Counter restarts whenever scrolling stops, so a new run always
  // counts a full interval of frame ticks before its first step.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !sif.run)
    begin
      frame_cnt_q <= 9'h000;
      step_q <= 1'b0;
    end
    else if (sif.frame_tick)
    begin
      if (frame_cnt_q + 9'h001 >= frames)
      begin
        frame_cnt_q <= 9'h000;
        step_q <= 1'b1; // see R11
      end
      else
      begin
        frame_cnt_q <= frame_cnt_q + 9'h001;
        step_q <= 1'b0;
      end
    end
    else
    begin
      step_q <= 1'b0;
    end
  end

  assign sif.step = step_q;

endmodule : ocsc_step_timer

`default_nettype wire

// ---- design/ocsc_top.sv ----
// Notes on behaviour
// R1 - D/C low is command, high display data
// R2 - Multi-byte opcodes collect parameters before next opcode
// R3 - 0x81 sets contrast, reset 0x7F
// R4 - 0xA5 all pixels on, 0xA4 follows memory
// R5 - 0xA6 normal, 0xA7 inverted pixels
// R6 - 0xAE display off (reset), 0xAF on
// R7 - 0xE3 changes nothing
// R8 - 0xFD parameter bit 2 sets lock
// R9 - Locked: ignore everything but 0xFD
// R10 - 0x26/0x27 horizontal scroll setup, seven parameters
// R11 - Interval code selects frames per step
// R12 - Page fields are plain binary 0 to 7
// R13 - Host keeps end page/column not below start
// R14 - 0x29/0x2A vertical plus right/left scroll
// R15 - Combined: column offset, pages, interval, vertical offset
// R16 - Vertical offset shifts rows per step
// R17 - 0x2E stops scrolling; host rewrites memory
// R18 - 0x2F starts latest setup; setups override
// R19 - 0xA3 fixed rows and scrolled rows
// R20 - Scroll region below fixed area, wraps around
// R21 - Combined vertical scroll confined to area
// R22 - 0x2C/0x2D shift content one column once
// R23 - Host keeps content end column above start
// R24 - Host spaces content scrolls two frames apart
`timescale 1ns/1ps
`default_nettype none

module ocsc_top
  import ocsc_pkg::*;
#(
  parameter int FRAME_CYCLES_P = FRAME_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host byte port
  input wire logic host_valid,
  input wire logic host_dc,
  input wire logic [7:0] host_byte,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Display state
  output logic [7:0] contrast_q,
  output logic entire_on_q,
  output logic inverse_q,
  output logic display_on_q,
  output logic cmd_locked_q,
  // Continuous scroll
  output logic scroll_active_q,
  output logic scroll_left_q,
  output logic scroll_vert_q,
  output logic [2:0] scroll_page_start_q,
  output logic [2:0] scroll_page_end_q,
  output logic [2:0] scroll_interval_q,
  output logic [7:0] scroll_col_start_q,
  output logic [7:0] scroll_col_end_q,
  output logic scroll_col_offset_q,
  output logic [5:0] scroll_voffset_q,
  output logic [5:0] fixed_rows_q,
  output logic [6:0] scroll_rows_q,
  output logic [6:0] hshift_q,
  output logic [6:0] vshift_q,
  output logic scroll_step_q,
  // One-column content scroll
  output logic content_shift_q,
  output logic content_left_q,
  output logic [2:0] content_page_start_q,
  output logic [2:0] content_page_end_q,
  output logic [7:0] content_col_start_q,
  output logic [7:0] content_col_end_q,
  // Display data
  output logic data_valid_q,
  output logic [7:0] data_byte_q
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (FRAME_CYCLES_P < 1 || FRAME_CYCLES_P >= (1 << FRAME_W))
  begin : g_bad_frame
    $error("FRAME_CYCLES_P does not fit the frame counter");
  end

  localparam logic [FRAME_W-1:0] FRAME_RST = FRAME_CYCLES_P[FRAME_W-1:0];

  // ---------------------------------------------------------------
  // Command decoder
  // ---------------------------------------------------------------
  ocsc_state_t state_q;
  logic [7:0] op_q;
  logic [2:0] idx_q;
  logic [2:0] need_q;
  logic [7:0] pbuf_q [0:5];
  logic cmd_byte;
  logic op_allowed;
  logic exec_single;
  logic exec_multi;
  logic [7:0] exec_op;

  assign cmd_byte = host_valid && !host_dc; // see R1
  assign op_allowed = !cmd_locked_q || (host_byte == OP_LOCK); // see R9
  assign exec_single = cmd_byte && (state_q == ST_OPCODE) && op_allowed
                       && (ocsc_nparams(host_byte) == 3'h0);
  assign exec_multi = cmd_byte && (state_q == ST_PARAM)
                      && (idx_q == need_q - 3'h1);
  assign exec_op = (state_q == ST_PARAM) ? op_q : host_byte;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= ST_OPCODE;
      op_q <= 8'h00;
      idx_q <= 3'h0;
      need_q <= 3'h0;
    end
    else if (cmd_byte)
    begin
      case (state_q)
        ST_OPCODE:
        begin
          if (op_allowed && ocsc_nparams(host_byte) != 3'h0)
          begin
            op_q <= host_byte;
            need_q <= ocsc_nparams(host_byte); // see R2
            idx_q <= 3'h0;
            state_q <= ST_PARAM;
          end
        end
        ST_PARAM:
        begin
          idx_q <= idx_q + 3'h1; // see R2
          if (idx_q == need_q - 3'h1)
          begin
            state_q <= ST_OPCODE;
          end
        end
        default: state_q <= ST_OPCODE;
      endcase
    end
  end

  // Parameter store; the last byte is used straight from the port
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 6; i++)
      begin
        pbuf_q[i] <= 8'h00;
      end
    end
    else if (cmd_byte && state_q == ST_PARAM && idx_q < 3'h6)
    begin
      pbuf_q[idx_q] <= host_byte; // see R2
    end
  end

  // ---------------------------------------------------------------
  // Fundamental settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      contrast_q <= RST_CONTRAST; // see R3
      entire_on_q <= 1'b0;
      inverse_q <= 1'b0;
      display_on_q <= 1'b0;
    end
    else if (exec_multi && exec_op == OP_CONTRAST)
    begin
      contrast_q <= host_byte; // see R3
    end
    else if (exec_single)
    begin
      // A NOP and the out-of-scope single-byte opcodes fall through
      case (exec_op)
        OP_ALL_OFF, OP_ALL_ON: entire_on_q <= exec_op[0]; // see R4
        OP_NORMAL, OP_INVERSE: inverse_q <= exec_op[0]; // see R5
        OP_DISP_OFF, OP_DISP_ON: display_on_q <= exec_op[0]; // see R6
        OP_NOP: display_on_q <= display_on_q; // see R7
        default: display_on_q <= display_on_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmd_locked_q <= 1'b0;
    end
    else if (exec_multi && exec_op == OP_LOCK)
    begin
      cmd_locked_q <= host_byte[LOCK_BIT]; // see R8
    end
  end

  // ---------------------------------------------------------------
  // Scroll configuration
  // ---------------------------------------------------------------
  // A later setup replaces the fields that it carries, and 0x26/0x27 also set the column offset back to 1; the rest keep their values.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scroll_left_q <= 1'b0;
      scroll_vert_q <= 1'b0;
      scroll_page_start_q <= RST_PAGE_START;
      scroll_page_end_q <= RST_PAGE_END;
      scroll_interval_q <= 3'h0;
      scroll_col_start_q <= RST_COL_START;
      scroll_col_end_q <= RST_COL_END;
      scroll_col_offset_q <= 1'b1;
      scroll_voffset_q <= 6'h00;
      fixed_rows_q <= RST_FIXED_ROWS;
      scroll_rows_q <= RST_SCROLL_ROWS;
    end
    else if (exec_multi)
    begin
      case (exec_op)
        OP_HSCR_R, OP_HSCR_L:
        begin
          scroll_left_q <= exec_op[0]; // see R10
          scroll_vert_q <= 1'b0;
          scroll_page_start_q <= pbuf_q[1][2:0]; // see R12
          scroll_interval_q <= pbuf_q[2][2:0];
          scroll_page_end_q <= pbuf_q[3][2:0]; // see R12
          scroll_col_start_q <= pbuf_q[5];
          scroll_col_end_q <= host_byte;
          scroll_col_offset_q <= 1'b1;
        end
        OP_VHSCR_R, OP_VHSCR_L:
        begin
          scroll_left_q <= exec_op[1]; // see R14
          scroll_vert_q <= 1'b1;
          scroll_col_offset_q <= pbuf_q[0][0]; // see R15
          scroll_page_start_q <= pbuf_q[1][2:0];
          scroll_interval_q <= pbuf_q[2][2:0];
          scroll_page_end_q <= pbuf_q[3][2:0];
          scroll_voffset_q <= host_byte[5:0]; // see R16
        end
        OP_VAREA:
        begin
          fixed_rows_q <= pbuf_q[0][5:0]; // see R19
          scroll_rows_q <= host_byte[6:0];
        end
        default: scroll_rows_q <= scroll_rows_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame divider
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] frame_period_q;
  logic [FRAME_W-1:0] frame_cnt_q;
  logic frame_tick_q;

  // A period written below the current count ends the frame at once.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      frame_cnt_q <= '0;
      frame_tick_q <= 1'b0;
    end
    else if (frame_cnt_q + 1'b1 >= frame_period_q)
    begin
      frame_cnt_q <= '0;
      frame_tick_q <= 1'b1;
    end
    else
    begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
      frame_tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Scroll run state and positions
  // ---------------------------------------------------------------
  ocsc_step_if sif ();
  logic [7:0] vsum;
  logic [6:0] hstep;

  assign sif.frame_tick = frame_tick_q;
  assign sif.run = scroll_active_q;
  assign sif.interval = scroll_interval_q; // see R11

  ocsc_step_timer u_step (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sif(sif)
  );

  assign hstep = {6'h00, scroll_col_offset_q};
  assign vsum = {1'b0, vshift_q} + {2'b00, scroll_voffset_q};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scroll_active_q <= 1'b0;
    end
    else if (exec_single && exec_op == OP_SCR_OFF)
    begin
      scroll_active_q <= 1'b0; // see R17
    end
    else if (exec_single && exec_op == OP_SCR_ON)
    begin
      scroll_active_q <= 1'b1; // see R18
    end
  end

  // Positions restart from zero on start and stop; after a stop the
  // memory image is stale anyway and must be rewritten by the host.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || (exec_single && (exec_op == OP_SCR_OFF
        || exec_op == OP_SCR_ON)))
    begin
      hshift_q <= 7'h00;
      vshift_q <= 7'h00;
      scroll_step_q <= 1'b0;
    end
    else
    begin
      // A step queued as scrolling stops must not move the image
      scroll_step_q <= sif.step && scroll_active_q;
      if (sif.step && scroll_active_q)
      begin
        hshift_q <= scroll_left_q ? hshift_q - hstep : hshift_q + hstep;
        if (scroll_vert_q && scroll_rows_q != 7'h00)
        begin
          // Wrap inside the scroll area below the fixed rows
          if (vsum >= {1'b0, scroll_rows_q})
          begin
            vshift_q <= 7'(vsum - {1'b0, scroll_rows_q}); // see R20
          end
          else
          begin
            vshift_q <= vsum[6:0]; // see R21
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // One-column content scroll
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      content_shift_q <= 1'b0;
      content_left_q <= 1'b0;
      content_page_start_q <= RST_PAGE_START;
      content_page_end_q <= RST_PAGE_END;
      content_col_start_q <= RST_COL_START;
      content_col_end_q <= RST_COL_END;
    end
    else if (exec_multi && (exec_op == OP_CSCR_R || exec_op == OP_CSCR_L))
    begin
      content_shift_q <= 1'b1; // see R22
      content_left_q <= exec_op[0];
      content_page_start_q <= pbuf_q[1][2:0];
      content_page_end_q <= pbuf_q[3][2:0];
      content_col_start_q <= pbuf_q[5];
      content_col_end_q <= host_byte;
    end
    else
    begin
      content_shift_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Display data pass-through
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      data_valid_q <= 1'b0;
      data_byte_q <= 8'h00;
    end
    else
    begin
      data_valid_q <= host_valid && host_dc && !cmd_locked_q; // see R9
      if (host_valid && host_dc)
      begin
        data_byte_q <= host_byte; // see R1
      end
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      frame_period_q <= FRAME_RST;
    end
    else if (reg_wr && reg_addr == REG_FRAME)
    begin
      frame_period_q <= reg_wdata[FRAME_W-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_STATUS:
          reg_rdata_q <= {24'h000000, scroll_vert_q, scroll_left_q,
                          scroll_active_q, cmd_locked_q, inverse_q,
                          entire_on_q, display_on_q, 1'b0};
        REG_FRAME:
          reg_rdata_q <= {{(32 - FRAME_W){1'b0}}, frame_period_q};
        REG_CONTRAST:
          reg_rdata_q <= {24'h000000, contrast_q};
        REG_SCROLL_POS:
          reg_rdata_q <= {17'h00000, vshift_q, 1'b0, hshift_q};
        default:
          reg_rdata_q <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

endmodule : ocsc_top

`default_nettype wire

// ---- test/ocsc_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module ocsc_top_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host and register strobes
  input wire logic host_valid,
  input wire logic host_dc,
  input wire logic [7:0] host_byte,
  input wire logic reg_rd,
  // Outputs watched
  input wire logic [31:0] reg_rdata_q,
  input wire logic [7:0] contrast_q,
  input wire logic display_on_q,
  input wire logic inverse_q,
  input wire logic cmd_locked_q,
  input wire logic scroll_active_q,
  input wire logic [6:0] hshift_q,
  input wire logic [6:0] vshift_q,
  input wire logic content_shift_q,
  input wire logic data_valid_q,
  input wire logic [7:0] data_byte_q
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic cmd_in;
  assign cmd_in = host_valid && !host_dc;

  AST_DATA_PASS: assert property (
    host_valid && host_dc && !cmd_locked_q
    |=> data_valid_q && data_byte_q == $past(host_byte))
    else $error("data byte not passed on");
  AST_NO_DATA: assert property (
    !(host_valid && host_dc) |=> !data_valid_q)
    else $error("data pulse without data byte");
  AST_LOCK_DATA: assert property (
    host_valid && host_dc && cmd_locked_q |=> !data_valid_q)
    else $error("data passed while locked");
  AST_LOCK_HOLD: assert property (
    cmd_locked_q |=> $stable(contrast_q) && $stable(display_on_q)
    && $stable(inverse_q))
    else $error("state changed while locked");
  AST_CMD_ONLY: assert property (
    !cmd_in |=> $stable(contrast_q) && $stable(cmd_locked_q)
    && $stable(display_on_q))
    else $error("state changed without a command byte");
  AST_SHIFT_ONCE: assert property (
    content_shift_q |=> !content_shift_q [*7])
    else $error("content shift pulses too close");
  AST_SCR_IDLE: assert property (
    !scroll_active_q |-> hshift_q == 7'h00 && vshift_q == 7'h00)
    else $error("scroll position moved while stopped");
  AST_RD_IDLE: assert property (
    !reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data without read strobe");

  cover property (content_shift_q);
  cover property ($rose(scroll_active_q));
  cover property ($rose(cmd_locked_q));
endmodule : ocsc_top_props

`default_nettype wire

// ---- test/ocsc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ocsc_host_model (
  // Clock
  input wire logic clk_sys,
  // Byte port
  output logic host_valid,
  output logic host_dc,
  output logic [7:0] host_byte
);
  initial
  begin
    host_valid = 1'b0;
    host_dc = 1'b1;
    host_byte = 8'h00;
  end

  // Idle lines flip so the block cannot lean on a stale byte
  task automatic send(input logic dc, input logic [7:0] b);
    @(posedge clk_sys);
    host_valid <= 1'b1;
    host_dc <= dc;
    host_byte <= b;
    @(posedge clk_sys);
    host_valid <= 1'b0;
    host_dc <= ~dc;
    host_byte <= ~b;
    #1;
  endtask : send
endmodule : ocsc_host_model

`default_nettype wire

// ---- test/oled_command_scroll_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module oled_command_scroll_control_tb;
  import ocsc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int FR = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic host_valid, host_dc, entire_on_q, inverse_q, display_on_q;
  logic cmd_locked_q, scroll_active_q, scroll_left_q, scroll_vert_q;
  logic scroll_col_offset_q, scroll_step_q, content_shift_q;
  logic content_left_q, data_valid_q;
  logic [2:0] scroll_page_start_q, scroll_page_end_q, scroll_interval_q;
  logic [2:0] content_page_start_q, content_page_end_q;
  logic [7:0] host_byte, contrast_q, scroll_col_start_q, scroll_col_end_q;
  logic [7:0] content_col_start_q, content_col_end_q, data_byte_q;
  logic [5:0] scroll_voffset_q, fixed_rows_q;
  logic [6:0] scroll_rows_q, hshift_q, vshift_q;
  logic [31:0] reg_rdata_q;
  logic [7:0] ops[6] = '{8'ha5, 8'ha7, 8'haf, 8'ha4, 8'ha6, 8'hae};
  logic [2:0] fl[6] = '{3'b100, 3'b110, 3'b111, 3'b011, 3'b001, 3'b000};
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h48fe;

  ocsc_top #(.FRAME_CYCLES_P(FR)) ocsc_top_i (.*);
  ocsc_host_model ocsc_host_model_i (.clk_sys(clk_sys),
    .host_valid(host_valid), .host_dc(host_dc), .host_byte(host_byte));

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic int frames(input logic [2:0] c);
    int t[8] = '{5, 64, 128, 256, 2, 3, 4, 1};
    return t[c];
  endfunction : frames

  task automatic cmd(input logic [7:0] b);
    ocsc_host_model_i.send(1'b0, b);
  endtask : cmd

  // Parameters packed first byte highest, n of them sent
  task automatic cmds(input logic [7:0] op, input logic [55:0] p,
                      input int n);
    cmd(op);
    for (int i = 0; i < n; i++)
      cmd(p[55 - 8 * i -: 8]);
  endtask : cmds

  task automatic reg_op(input logic wr, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata_q;
  endtask : reg_op

  task automatic wait_step(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (scroll_step_q !== 1'b1 && n < 3000);
  endtask : wait_step

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] q;
    logic [7:0] a, b, c, con;
    int n;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(contrast_q, RST_CONTRAST);
    check({entire_on_q, inverse_q, display_on_q}, 3'b000);
    check(cmd_locked_q, 1'b0);
    check({scroll_col_start_q, scroll_col_end_q}, 16'h007f);
    check({fixed_rows_q, scroll_rows_q}, {6'h00, 7'h40});
    reg_op(1'b1, REG_FRAME, FR, q);
    reg_op(1'b0, REG_FRAME, 0, q);
    check(q, FR);
    reg_op(1'b0, 4'h2, 0, q);
    check(q, 32'h0);
    repeat (6)
    begin
      con = $random(seed);
      b = $random(seed);
      cmd(OP_CONTRAST);
      ocsc_host_model_i.send(1'b1, b);
      check({data_valid_q, data_byte_q}, {1'b1, b});
      cmd(con);
      reg_op(1'b0, REG_CONTRAST, 0, q);
      check(q, {24'h0, con});
    end
    foreach (ops[i])
    begin
      cmd(ops[i]);
      cmd(OP_NOP);
      check({entire_on_q, inverse_q, display_on_q}, fl[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      a = $random(seed) & 8'h07;
      b = (a | $random(seed)) & 8'h07;
      c = $random(seed) & 8'h3f;
      cmds(i[0] ? OP_HSCR_L : OP_HSCR_R,
           {8'h00, a, i[7:0], b, 8'h00, c, c | 8'h40}, 7);
      check({scroll_page_start_q, scroll_page_end_q, scroll_interval_q},
            {a[2:0], b[2:0], i[2:0]});
      check({scroll_col_start_q, scroll_col_end_q, scroll_left_q},
            {c, c | 8'h40, i[0]});
      cmd(OP_SCR_ON);
      check(scroll_active_q, 1'b1);
      wait_step(n);
      wait_step(n);
      check(n, frames(i[2:0]) * FR);
      check(hshift_q, i[0] ? 7'd126 : 7'd2);
      cmd(OP_SCR_OFF);
      check({scroll_active_q, hshift_q}, 8'h00);
    end
    cmds(OP_VAREA, {8'h08, 8'h28, 40'h0}, 2);
    check({fixed_rows_q, scroll_rows_q}, {6'h08, 7'h28});
    cmds(OP_HSCR_R, 56'h0, 7);
    cmds(OP_VHSCR_L, {8'h00, 8'h00, 8'h07, 8'h07, 8'h1e, 16'h0}, 5);
    check({scroll_vert_q, scroll_left_q, scroll_col_offset_q,
           scroll_voffset_q}, {3'b110, 6'h1e});
    cmd(OP_SCR_ON);
    wait_step(n);
    wait_step(n);
    // Two steps of 30 rows wrap inside a 40-row area
    check({vshift_q, hshift_q}, {7'd20, 7'd0});
    reg_op(1'b0, REG_SCROLL_POS, 0, q);
    check(q, {17'h0, 7'd20, 8'h00});
    cmd(OP_SCR_OFF);
    for (int k = 0; k < 2; k++)
    begin
      c = $random(seed) & 8'h3f;
      cmds(k[0] ? OP_CSCR_L : OP_CSCR_R,
           {8'h00, 8'h01, 8'h01, 8'h03, 8'h00, c, c | 8'h40}, 7);
      check({content_shift_q, content_left_q, content_page_start_q,
             content_page_end_q}, {1'b1, k[0], 3'd1, 3'd3});
      check({content_col_start_q, content_col_end_q},
            {c, c | 8'h40});
      repeat (2 * FR) @(posedge clk_sys);
    end
    cmds(OP_LOCK, {8'h16, 48'h0}, 1);
    check(cmd_locked_q, 1'b1);
    reg_op(1'b0, REG_STATUS, 0, q);
    check(q, 32'hd0);
    cmd(OP_DISP_ON);
    cmds(OP_CONTRAST, {8'h11, 48'h0}, 1);
    ocsc_host_model_i.send(1'b1, 8'h5a);
    check(data_valid_q, 1'b0);
    check({display_on_q, contrast_q}, {1'b0, con});
    cmds(OP_LOCK, {8'hfb, 48'h0}, 1);
    check(cmd_locked_q, 1'b0);
    cmd(OP_DISP_ON);
    check(display_on_q, 1'b1);
    complete_run();
  end
endmodule : oled_command_scroll_control_tb

bind ocsc_top ocsc_top_props ocsc_top_props_i (.*);

`default_nettype wire
